// File: core/adc_seq_regs.svh
// timing counts and field constants for the conversion sequencer
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// default length of one conversion period in mclk_i cycles
`define CONV_CYCLES_DEF 16
// default result width
`define RESULT_W_DEF    16
// index of the conversion that yields the result (three priming ones come first)
`define PRIME_CONV      2'h3
// count loaded at an input switch: three conversions are discarded, the result of the fourth is good
`define SETTLE_CONV     3'h4
`define SETTLE_ONE      3'h1
`define SETTLE_NONE     3'h0
`define SEQ_FIRST       2'h0
`define SEQ_STEP        2'h1

`endif

// File: core/adc_seq_pkg.sv
// types shared by the conversion sequencer
package adc_seq_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_CONT   = 2'h1,
    MODE_MULTI  = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_CONV   = 2'h1,
    ST_STREAM = 2'h2,
    ST_HOLD   = 2'h3
  } state_t;

endpackage : adc_seq_pkg

// File: core/adc_conversion_sequencer.sv
// conversion sequencer: trigger, decimator priming, done flag and the three modes
// Summary of operation
// - single mode waits in standby for trigger
// - trigger runs four conversions, three prime
// - done rises when fourth conversion completes
// - done is pollable status and request line
// - after result read, return to standby
// - continuous: first result after three priming
// - continuous: then one result every period
// - multi: re-prime decimator before each sample
// - multi: next sample starts by itself
// - done rises after every result conversion
// - start bit or trigger begins a sequence
// - done holds until result read clears it
// - results invalid until fourth after switch
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

module adc_conversion_sequencer #(
  parameter int CONV_CYCLES = `CONV_CYCLES_DEF,
  parameter int RESULT_W    = `RESULT_W_DEF
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  reset_n_i,
  // control from software or same-clock logic
  input  wire adc_seq_pkg::mode_t    mode_i,
  input  wire logic                  start_i,
  input  wire logic                  stop_i,
  input  wire logic                  mux_switch_i,
  // external trigger, may be a pin or a programmable_logic_block output
  input  wire logic                  soc_i,
  // decimator side
  input  wire logic [RESULT_W-1:0]   sample_i,
  output logic                       dec_clear_o,
  output logic                       conv_end_o,
  // result consumer side
  input  wire logic                  rd_i,
  output logic                       eoc_o,
  output logic [RESULT_W-1:0]        result_o,
  output logic                       result_valid_o,
  output logic                       busy_o
);

  localparam int CW = (CONV_CYCLES > 1) ? $clog2(CONV_CYCLES) : 1;
  localparam logic [CW-1:0] PER_LAST = CW'(CONV_CYCLES - 1);
  localparam logic [CW-1:0] PER_ZERO = '0;

  adc_seq_pkg::state_t state_q;
  adc_seq_pkg::mode_t  mode_q;
  logic [CW-1:0]       per_cnt_q;
  logic [1:0]          seq_cnt_q;
  logic [2:0]          settle_cnt_q;
  logic                soc_meta_q;
  logic                soc_sync_q;
  logic                soc_last_q;
  logic                done_q;
  logic                valid_q;
  logic                clear_q;
  logic [RESULT_W-1:0] result_q;

  logic soc_rise;
  logic go;
  logic running;
  logic conv_end;
  logic result_evt;
  logic last_of_seq;

  // trigger may come from any clock, so it is synchronised before edge detection
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      soc_meta_q <= 1'b0;
      soc_sync_q <= 1'b0;
      soc_last_q <= 1'b0;
    end
    else
    begin
      soc_meta_q <= soc_i;
      soc_sync_q <= soc_meta_q;
      soc_last_q <= soc_sync_q;
    end
  end

  assign soc_rise    = soc_sync_q & ~soc_last_q;
  // only accepted from standby; requests while busy are dropped
  assign go          = (start_i | soc_rise) && (state_q == adc_seq_pkg::ST_IDLE);
  assign running     = (state_q == adc_seq_pkg::ST_CONV) || (state_q == adc_seq_pkg::ST_STREAM);
  assign conv_end    = running && (per_cnt_q == PER_ZERO);
  assign last_of_seq = (seq_cnt_q == `PRIME_CONV);
  assign result_evt  = conv_end && ((state_q == adc_seq_pkg::ST_STREAM) ||
                       ((state_q == adc_seq_pkg::ST_CONV) && last_of_seq));

  // conversion period timer
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      per_cnt_q <= PER_ZERO;
    else if (go || conv_end)
      per_cnt_q <= PER_LAST;
    else if (running)
      per_cnt_q <= per_cnt_q - CW'(1);
  end

  // sequence state
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q   <= adc_seq_pkg::ST_IDLE;
      mode_q    <= adc_seq_pkg::MODE_SINGLE;
      seq_cnt_q <= `SEQ_FIRST;
    end
    else
    begin
      unique case (state_q)
        adc_seq_pkg::ST_IDLE:
        begin
          if (go)
          begin
            state_q   <= adc_seq_pkg::ST_CONV;
            mode_q    <= (mode_i == adc_seq_pkg::MODE_CONT || mode_i == adc_seq_pkg::MODE_MULTI) ?
                         mode_i : adc_seq_pkg::MODE_SINGLE;
            seq_cnt_q <= `SEQ_FIRST;
          end
        end
        adc_seq_pkg::ST_CONV:
        begin
          if (stop_i)
            state_q <= adc_seq_pkg::ST_IDLE;
          else if (conv_end && last_of_seq)
          begin
            seq_cnt_q <= `SEQ_FIRST;
            unique case (mode_q)
              adc_seq_pkg::MODE_CONT:  state_q <= adc_seq_pkg::ST_STREAM;
              adc_seq_pkg::MODE_MULTI: state_q <= adc_seq_pkg::ST_CONV;
              default:                 state_q <= adc_seq_pkg::ST_HOLD;
            endcase
          end
          else if (conv_end)
            seq_cnt_q <= seq_cnt_q + `SEQ_STEP;
        end
        adc_seq_pkg::ST_STREAM:
        begin
          if (stop_i)
            state_q <= adc_seq_pkg::ST_IDLE;
        end
        adc_seq_pkg::ST_HOLD:
        begin
          // single mode waits for the consumer before rearming
          if (rd_i)
            state_q <= adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // decimator clear: one pulse on an accepted start and at the head of each further multi-mode sample
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      clear_q <= 1'b0;
    else
      clear_q <= go || (conv_end && last_of_seq && !stop_i && (state_q == adc_seq_pkg::ST_CONV) &&
                 (mode_q == adc_seq_pkg::MODE_MULTI));
  end

  // result capture
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      result_q <= '0;
    else if (result_evt)
      result_q <= sample_i;
  end

  // done flag: a new result in the read cycle keeps it set
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      done_q <= 1'b0;
    else if (result_evt)
      done_q <= 1'b1;
    else if (rd_i)
      done_q <= 1'b0;
  end

  // settling after an input switch; the decimator still holds old-input history
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      settle_cnt_q <= `SETTLE_NONE;
    else if (mux_switch_i)
      settle_cnt_q <= `SETTLE_CONV;
    else if (conv_end && (settle_cnt_q != `SETTLE_NONE))
      settle_cnt_q <= settle_cnt_q - `SETTLE_ONE;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      valid_q <= 1'b0;
    else if (result_evt)
      valid_q <= !mux_switch_i && (settle_cnt_q <= `SETTLE_ONE);
  end

  assign dec_clear_o    = clear_q;
  assign conv_end_o     = conv_end;
  assign eoc_o          = done_q;
  assign result_o       = result_q;
  assign result_valid_o = valid_q;
  assign busy_o         = (state_q != adc_seq_pkg::ST_IDLE);

  // helper: conversions seen since the last decimator clear
  logic [2:0] seen_q;
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      seen_q <= 3'h0;
    else if (clear_q)
      seen_q <= 3'h0;
    else if (conv_end && (seen_q != 3'h7))
      seen_q <= seen_q + 3'h1;
  end

  // helper: cycles since the last accepted start or conversion end, counted apart from the period timer
  localparam logic [CW:0] GAP_LAST = (CW+1)'(CONV_CYCLES - 1);
  localparam logic [CW:0] GAP_MAX  = '1;
  logic [CW:0] gap_q;
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gap_q <= '0;
    else if (go || conv_end)
      gap_q <= '0;
    else if (gap_q != GAP_MAX)
      gap_q <= gap_q + (CW+1)'(1);
  end

  idle_wait_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (state_q == adc_seq_pkg::ST_IDLE) && !start_i && !soc_rise |=> (state_q == adc_seq_pkg::ST_IDLE))
    else $error("left standby without a start");

  four_conv_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt && (state_q == adc_seq_pkg::ST_CONV) |-> (seen_q == 3'h3))
    else $error("result not on the fourth conversion");

  done_rise_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt |=> eoc_o && (result_o == $past(sample_i)))
    else $error("done or result missing after conversion");

  done_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    eoc_o && !rd_i |=> eoc_o)
    else $error("done dropped without a read");

  done_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rd_i && !result_evt |=> !eoc_o)
    else $error("read did not clear done");

  hold_return_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (state_q == adc_seq_pkg::ST_HOLD) && rd_i |=> (state_q == adc_seq_pkg::ST_IDLE))
    else $error("no return to standby after read");

  stream_rate_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt && (state_q == adc_seq_pkg::ST_STREAM) && !stop_i |=> !result_evt [*2])
    else $error("stream results too close");

  stream_each_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    conv_end && (state_q == adc_seq_pkg::ST_STREAM) |-> result_evt && (gap_q == GAP_LAST))
    else $error("stream conversion off period or without result");

  multi_restart_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt && (state_q == adc_seq_pkg::ST_CONV) && (mode_q == adc_seq_pkg::MODE_MULTI) && !stop_i
    |=> dec_clear_o && (state_q == adc_seq_pkg::ST_CONV) && (seq_cnt_q == `SEQ_FIRST))
    else $error("multi sample did not restart primed");

  start_go_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    start_i && (state_q == adc_seq_pkg::ST_IDLE) |=> busy_o && dec_clear_o)
    else $error("start bit did not begin a sequence");

  busy_ignore_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    start_i && busy_o |=> !dec_clear_o || $past(conv_end))
    else $error("start restarted a running sequence");

  settle_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt && (mux_switch_i || (settle_cnt_q > `SETTLE_ONE)) |=> !result_valid_o)
    else $error("result marked valid too early after switch");

  single_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    (state_q == adc_seq_pkg::ST_HOLD) && rd_i);
  stream_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt && (state_q == adc_seq_pkg::ST_STREAM));
  multi_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    result_evt && (mode_q == adc_seq_pkg::MODE_MULTI) ##1 dec_clear_o);
  ignore_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    start_i && busy_o);
  switch_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    mux_switch_i ##[1:200] (result_evt && (settle_cnt_q == `SETTLE_ONE)));

endmodule : adc_conversion_sequencer

// File: dv/result_reader.sv
// result consumer and decimator stand-in facing the conversion sequencer
`timescale 1ns/1ps
module result_reader (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // bench control: low holds the read back, a slow consumer
  input  wire logic        rd_en_i,
  // sequencer side
  input  wire logic        eoc_i,
  output logic [15:0]      sample_o,
  output logic             rd_o
);
  // word moves every cycle so a stale capture never matches
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i) sample_o <= 16'h0;
    else sample_o <= sample_o + 16'h1357;
  end

  // one-cycle read strobe once done is seen
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i) rd_o <= 1'b0;
    else rd_o <= rd_en_i && eoc_i && !rd_o;
  end
endmodule : result_reader

// File: dv/adc_conversion_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  localparam int CC = 4;
  logic               mclk_i    = 1'b0;
  logic               reset_n_i = 1'b0;
  adc_seq_pkg::mode_t mode_i    = adc_seq_pkg::MODE_SINGLE;
  logic [3:0]         pls       = 4'h0;
  logic               rd_en     = 1'b0;
  logic [15:0]        sample, result_o, last_smp;
  logic               rd, dec_clear_o, conv_end_o, eoc_o, result_valid_o, busy_o, eoc_q;
  int                 n_mismatch, check_count, n_ce, n_dc, n_res, n;

  always #20 mclk_i = ~mclk_i;

  adc_conversion_sequencer #(.CONV_CYCLES(CC), .RESULT_W(16)) dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mode_i(mode_i), .start_i(pls[0]),
    .stop_i(pls[1]), .mux_switch_i(pls[2]), .soc_i(pls[3]), .sample_i(sample),
    .dec_clear_o(dec_clear_o), .conv_end_o(conv_end_o), .rd_i(rd), .eoc_o(eoc_o),
    .result_o(result_o), .result_valid_o(result_valid_o), .busy_o(busy_o));

  result_reader reader (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .rd_en_i(rd_en),
    .eoc_i(eoc_o), .sample_o(sample), .rd_o(rd));

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic pulse(input int w);
    @(posedge mclk_i);
    pls[w] <= 1'b1;
    @(posedge mclk_i);
    pls[w] <= 1'b0;
  endtask : pulse

  task automatic wait_eoc(output int c);
    c = 0;
    do
    begin
      tick();
      c++;
    end while (eoc_o !== 1'b1 && c < 300);
    if (c >= 300)
    begin
      chk(1'b0, "no result");
      wrap_up();
    end
  endtask : wait_eoc

  // result word must be the decimator word taken at the closing conversion
  always @(posedge mclk_i)
  begin
    if (conv_end_o === 1'b1) n_ce++;
    if (dec_clear_o === 1'b1) n_dc++;
    if (conv_end_o === 1'b1) last_smp <= sample;
    if (eoc_o === 1'b1 && eoc_q !== 1'b1)
    begin
      n_res++;
      chk(result_o === last_smp, "result word");
    end
    eoc_q <= eoc_o;
  end

  task automatic t_single;
    repeat (20) tick();
    chk(busy_o === 1'b0 && eoc_o === 1'b0, "left standby");
    n_ce = 0;
    pulse(0);
    pulse(0);
    pulse(3);
    wait_eoc(n);
    // the wait opens four edges after the accepted start, behind the two ignored pulses
    chk(n == 4 * CC - 4 && n_ce == 4, "single timing");
    chk(result_valid_o === 1'b1, "single valid");
    repeat (8) tick();
    chk(eoc_o === 1'b1 && busy_o === 1'b1, "done dropped");
    @(posedge mclk_i);
    rd_en <= 1'b1;
    repeat (4) tick();
    chk(eoc_o === 1'b0 && busy_o === 1'b0, "no standby");
    repeat (10) tick();
    chk(busy_o === 1'b0, "restarted alone");
  endtask : t_single

  task automatic t_trig;
    pulse(3);
    wait_eoc(n);
    chk(n >= 4 * CC + 1 && n <= 4 * CC + 5, "trigger timing");
    repeat (4) tick();
  endtask : t_trig

  // input kept on one signal while streaming
  task automatic t_cont;
    @(posedge mclk_i);
    mode_i <= adc_seq_pkg::MODE_CONT;
    pulse(0);
    wait_eoc(n);
    chk(n == 4 * CC, "first stream result");
    n_ce = 0;
    n_res = 0;
    repeat (3 * CC) tick();
    chk(n_res == 3 && n_ce == 3, "stream rate");
    pulse(1);
    tick();
    chk(busy_o === 1'b0, "stop ignored");
  endtask : t_cont

  task automatic t_multi;
    @(posedge mclk_i);
    mode_i <= adc_seq_pkg::MODE_MULTI;
    pulse(0);
    wait_eoc(n);
    n_ce = 0;
    n_dc = 0;
    while (n_ce < 2 && n < 600)
    begin
      tick();
      n++;
    end
    if (n_ce < 2)
    begin
      chk(1'b0, "multi stalled");
      wrap_up();
    end
    pulse(2);
    wait_eoc(n);
    chk(result_valid_o === 1'b0, "valid after switch");
    chk(n_ce == 4 && n_dc == 1, "no re-prime");
    repeat (3) tick();
    wait_eoc(n);
    chk(result_valid_o === 1'b1 && n_ce == 8 && n_dc == 2, "second sample");
    pulse(1);
    tick();
  endtask : t_multi

  initial
  begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_single();
    t_trig();
    t_cont();
    t_multi();
    wrap_up();
  end
endmodule : adc_conversion_sequencer_test
